// ===== rtl/hat_regs.sv
`timescale 1ns/1ps
// How it works
// [R1] software runs undriven fan outputs in mode 1
// [R2] each speed input tied to a drive output
// [R3] zone enables gate thermal status; reset 0Eh
// [R4] thermal group enable drives alert pin low
// [R5] lock bit makes registers ignore writes; write-one clears to 83h still land
// [R6] standby bit0, battery bit1; others read zero
// [R7] fault when at/below low or above high
// [R8] sticky status, write-one clear after event ends
// [R9] group or global enable clear keeps status
// [R10] 10-bit conversions averaged to 12-bit readings
// [R11] reading upper byte latches four low bits
// [R12] low-bit nibble pairs at 84h through 88h
// [R13] software never writes test registers 8Bh/8Dh
// [R14] partial edge count forces FFFFh or FFFEh
// [R15] edge select 2,3,5,9 edges; default five
// [R16] bit3 selects mode; options reset 04h
// [R17] unused or fast-drive inputs stay mode 1
// [R18] mode 2 skip first three edges option
// [R19] global alert enable gates the alert pin
module hat_regs
  import hat_pkg::*;
#(
  parameter int         NUM_SPEED = 3,
  parameter int         CNT_W     = 16,
  parameter logic [7:0] TEST_A_ID = 8'h00, // arbitrary value
  parameter logic [7:0] TEST_D_ID = 8'h00  // arbitrary value
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  // host register port
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  // configuration held elsewhere in the monitor
  input  wire logic                      config_lock,
  input  wire logic [7:0]                special_func,
  input  wire logic [7:0]                volt_enable,
  // averaged readings, 12-bit, and the rail limits
  input  wire logic [11:0]               reading_standby,
  input  wire logic [11:0]               reading_battery,
  input  wire logic [11:0]               reading_rd1,
  input  wire logic [11:0]               reading_rd2,
  input  wire logic [11:0]               reading_ambient,
  input  wire logic [11:0]               reading_12v,
  input  wire logic [11:0]               reading_2v5,
  input  wire logic [11:0]               reading_5v,
  input  wire logic [11:0]               reading_core,
  input  wire logic [11:0]               reading_main,
  input  wire logic                      reading_strobe,
  input  wire logic [7:0]                standby_low_limit,
  input  wire logic [7:0]                standby_high_limit,
  input  wire logic [7:0]                battery_low_limit,
  input  wire logic [7:0]                battery_high_limit,
  // upper byte reads that latch low bits, one per reading
  input  wire logic [9:0]                upper_byte_read,
  // thermal zone out-of-limit events: amb, zone1, zone3
  input  wire logic [2:0]                zone_event,
  // speed measurement timing and inputs
  input  wire logic [NUM_SPEED-1:0]      speed_window_start,
  input  wire logic [NUM_SPEED-1:0]      speed_window_end,
  input  wire logic [NUM_SPEED-1:0]      speed_guard_done,
  input  wire logic [NUM_SPEED-1:0]      speed_pin,
  output logic      [NUM_SPEED*CNT_W-1:0] speed_reading,
  output logic      [NUM_SPEED-1:0]      speed_reading_valid,
  output logic      [2:0]                zone_status,
  output logic      [7:0]                rail_status,
  output logic                           monitor_alert_n
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0]  thermal_alert_enable_q;
  logic [1:0]  rail_fault_q;
  logic [2:0]  zone_status_q;
  logic [7:0]  test_writable_b_q;
  logic [7:0]  test_writable_c_q;
  logic [7:0]  speed_opt_q [NUM_SPEED];
  logic [7:0]  low_bits_q  [5];
  logic [2:0]  pin_s1_q;
  logic [2:0]  pin_s2_q;
  logic [NUM_SPEED-1:0] sp_s1_q;
  logic [NUM_SPEED-1:0] sp_s2_q;
  logic [NUM_SPEED-1:0] sp_s3_q;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire logic wr_ok      = reg_wr & ~config_lock; // [R5]
  wire logic wr_therm   = wr_ok & (reg_addr == HAT_OFF_THERM_EN);
  wire logic wr_stat    = reg_wr & (reg_addr == HAT_OFF_RAIL_STAT);
  wire logic wr_test_b  = wr_ok & (reg_addr == HAT_OFF_TEST_WB);
  wire logic wr_test_c  = wr_ok & (reg_addr == HAT_OFF_TEST_WC);
  wire logic in_speed   = (reg_addr >= HAT_OFF_SPEED1) & (reg_addr <= HAT_OFF_SPEED3);
  wire logic [7:0] sp_ix = reg_addr - HAT_OFF_SPEED1;

  // ---------------------------------------------------------------
  // rail fault detection
  // ---------------------------------------------------------------
  function automatic logic hat_out_of_limit(input logic [7:0] rd, input logic [7:0] lo,
                                            input logic [7:0] hi);
    hat_out_of_limit = (rd <= lo) | (rd > hi); // [R7]
  endfunction : hat_out_of_limit

  // only the upper byte of the averaged reading is compared
  wire logic sb_fault  = hat_out_of_limit(reading_standby[11:4], standby_low_limit,
                                          standby_high_limit); // [R11]
  wire logic bat_fault = hat_out_of_limit(reading_battery[11:4], battery_low_limit,
                                          battery_high_limit);
  wire logic [1:0] rail_ev  = {bat_fault, sb_fault} & {2{reading_strobe}};
  wire logic [1:0] rail_ien = {volt_enable[HAT_VEN_VBAT], volt_enable[HAT_VEN_VTR]};
  // clear only lands once the event has gone
  wire logic [1:0] rail_clr = {2{wr_stat}} & reg_wdata[1:0] & ~{bat_fault, sb_fault};

  // set beats clear; dropping the individual enable clears
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rail_fault_q <= HAT_RST_RAIL_STAT[1:0];
    else if (clk_en) rail_fault_q <= ((rail_fault_q & ~rail_clr) | rail_ev) & rail_ien; // [R6] [R8]
  end

  // ---------------------------------------------------------------
  // thermal zones
  // ---------------------------------------------------------------
  // zone events come from pins of the sensing front end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else if (clk_en) begin
      pin_s1_q <= zone_event;
      pin_s2_q <= pin_s1_q;
    end
  end

  wire logic [2:0] zone_ien = {thermal_alert_enable_q[HAT_THERM_ZONE3],
                               thermal_alert_enable_q[HAT_THERM_ZONE1],
                               thermal_alert_enable_q[HAT_THERM_AMB]};

  // zone status sits elsewhere in the map; kept here to drive the pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) zone_status_q <= 3'h0;
    else if (clk_en) zone_status_q <= (zone_status_q | pin_s2_q) & zone_ien; // [R3] [R8]
  end

  // group/global enables only gate the pin, never the status bits
  wire logic therm_alert = thermal_alert_enable_q[HAT_THERM_GROUP] & (|zone_status_q); // [R4] [R9]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) monitor_alert_n <= 1'b1;
    else if (clk_en) monitor_alert_n <= ~(therm_alert & special_func[HAT_SPECIAL_GAE]); // [R19]
  end

  // ---------------------------------------------------------------
  // writable configuration
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thermal_alert_enable_q <= HAT_RST_THERM_EN; // [R3]
      test_writable_b_q      <= HAT_RST_TEST_B;
      test_writable_c_q      <= HAT_RST_TEST_C;
    end else if (clk_en) begin
      if (wr_therm) thermal_alert_enable_q <= reg_wdata & HAT_MASK_THERM;
      if (wr_test_b) test_writable_b_q <= reg_wdata & HAT_MASK_TEST_B; // [R13]
      if (wr_test_c) test_writable_c_q <= reg_wdata & HAT_MASK_TEST_C; // [R13]
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SPEED; g++) begin : g_speed
      wire logic wr_sp = wr_ok & in_speed & (sp_ix == 8'(g)); // [R5]

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) speed_opt_q[g] <= HAT_RST_SPEED; // [R16]
        else if (clk_en && wr_sp) speed_opt_q[g] <= reg_wdata & HAT_MASK_SPEED;
      end

      // mode 1 is the software's choice for idle inputs
      hat_speed_meas #(
        .CNT_W (CNT_W)
      ) u_meas (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .clk_en       (clk_en),
        .options      (speed_opt_q[g]), // [R1] [R2] [R17]
        .window_start (speed_window_start[g]),
        .window_end   (speed_window_end[g]),
        .guard_done   (speed_guard_done[g]),
        .edge_seen    (sp_s2_q[g] & ~sp_s3_q[g]),
        .speed_count  (speed_reading[g*CNT_W +: CNT_W]),
        .speed_valid  (speed_reading_valid[g])
      );
    end
  endgenerate

  // speed pins: two-stage sync, third stage only for the edge
  // reset high like an idle pulled-up pin, so no false edge follows reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sp_s1_q <= '1;
      sp_s2_q <= '1;
      sp_s3_q <= '1;
    end else if (clk_en) begin
      sp_s1_q <= speed_pin;
      sp_s2_q <= sp_s1_q;
      sp_s3_q <= sp_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // low-bit latches
  // ---------------------------------------------------------------
  // readings arrive already averaged to 12 bits from 10-bit samples
  wire logic [11:0] rd_all [10] = '{reading_standby, reading_battery, reading_rd2,
                                    reading_rd1, reading_12v, reading_ambient,
                                    reading_5v, reading_2v5, reading_main, reading_core}; // [R10]

  generate
    for (g = 0; g < 5; g++) begin : g_low
      // upper nibble is the first-named reading of the pair
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) low_bits_q[g] <= 8'h00;
        else if (clk_en) begin
          if (upper_byte_read[2*g]) low_bits_q[g][7:4] <= rd_all[2*g][3:0]; // [R11] [R12]
          if (upper_byte_read[2*g+1]) low_bits_q[g][3:0] <= rd_all[2*g+1][3:0]; // [R12]
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      HAT_OFF_THERM_EN:  rd_mux = thermal_alert_enable_q;
      HAT_OFF_RAIL_STAT: rd_mux = {6'h00, rail_fault_q}; // [R6]
      HAT_OFF_LSB_SB:    rd_mux = low_bits_q[0];
      HAT_OFF_LSB_RD:    rd_mux = low_bits_q[1];
      HAT_OFF_LSB_12A:   rd_mux = low_bits_q[2];
      HAT_OFF_LSB_5V:    rd_mux = low_bits_q[3];
      HAT_OFF_LSB_MC:    rd_mux = low_bits_q[4];
      HAT_OFF_TEST_A:    rd_mux = TEST_A_ID;
      HAT_OFF_TEST_RB:   rd_mux = HAT_RST_TEST_B;
      HAT_OFF_TEST_WB:   rd_mux = test_writable_b_q;
      HAT_OFF_TEST_RC:   rd_mux = HAT_RST_TEST_C;
      HAT_OFF_TEST_WC:   rd_mux = test_writable_c_q;
      HAT_OFF_TEST_D:    rd_mux = TEST_D_ID;
      default: begin
        if (in_speed) rd_mux = speed_opt_q[sp_ix[1:0]];
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (clk_en && reg_rd) reg_rdata <= rd_mux;
  end

  assign zone_status = zone_status_q;
  assign rail_status = {6'h00, rail_fault_q};

endmodule : hat_regs

// ===== rtl/hat_pkg.sv
package hat_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] HAT_OFF_SPECIAL   = 8'h7C;
  localparam logic [7:0] HAT_OFF_VOLT_EN   = 8'h7E;
  localparam logic [7:0] HAT_OFF_THERM_EN  = 8'h82;
  localparam logic [7:0] HAT_OFF_RAIL_STAT = 8'h83;
  localparam logic [7:0] HAT_OFF_LSB_SB    = 8'h84;
  localparam logic [7:0] HAT_OFF_LSB_RD    = 8'h85;
  localparam logic [7:0] HAT_OFF_LSB_12A   = 8'h86;
  localparam logic [7:0] HAT_OFF_LSB_5V    = 8'h87;
  localparam logic [7:0] HAT_OFF_LSB_MC    = 8'h88;
  localparam logic [7:0] HAT_OFF_TEST_A    = 8'h89;
  localparam logic [7:0] HAT_OFF_TEST_RB   = 8'h8A;
  localparam logic [7:0] HAT_OFF_TEST_WB   = 8'h8B;
  localparam logic [7:0] HAT_OFF_TEST_RC   = 8'h8C;
  localparam logic [7:0] HAT_OFF_TEST_WC   = 8'h8D;
  localparam logic [7:0] HAT_OFF_TEST_D    = 8'h8E;
  localparam logic [7:0] HAT_OFF_SPEED1    = 8'h90;
  localparam logic [7:0] HAT_OFF_SPEED3    = 8'h92;

  // ---------------------------------------------------------------
  // reset values and write masks
  // ---------------------------------------------------------------
  localparam logic [7:0] HAT_RST_THERM_EN  = 8'h0E;
  localparam logic [7:0] HAT_RST_RAIL_STAT = 8'h00;
  localparam logic [7:0] HAT_RST_TEST_B    = 8'h4D;
  localparam logic [7:0] HAT_RST_TEST_C    = 8'h0E;
  localparam logic [7:0] HAT_RST_SPEED     = 8'h04;
  localparam logic [7:0] HAT_MASK_TEST_B   = 8'h7F;
  localparam logic [7:0] HAT_MASK_TEST_C   = 8'h1F;
  localparam logic [7:0] HAT_MASK_SPEED    = 8'h1F;
  localparam logic [7:0] HAT_MASK_THERM    = 8'h0F;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int HAT_THERM_GROUP  = 0;
  localparam int HAT_THERM_AMB    = 1;
  localparam int HAT_THERM_ZONE1  = 2;
  localparam int HAT_THERM_ZONE3  = 3;
  localparam int HAT_SPECIAL_GAE  = 2;
  localparam int HAT_VEN_VBAT     = 1;
  localparam int HAT_VEN_VTR      = 4;
  localparam int HAT_STAT_SB      = 0;
  localparam int HAT_STAT_BAT     = 1;
  localparam int HAT_OPT_SLOW     = 0;
  localparam int HAT_OPT_EDG_LO   = 1;
  localparam int HAT_OPT_EDG_HI   = 2;
  localparam int HAT_OPT_MODE     = 3;
  localparam int HAT_OPT_SKIP     = 4;

  // ---------------------------------------------------------------
  // speed measurement constants
  // ---------------------------------------------------------------
  localparam logic [15:0] HAT_SPEED_PART_SLOW0 = 16'hFFFF;
  localparam logic [15:0] HAT_SPEED_PART_SLOW1 = 16'hFFFE;
  localparam logic [3:0]  HAT_EDGES_00         = 4'h2;
  localparam logic [3:0]  HAT_EDGES_01         = 4'h3;
  localparam logic [3:0]  HAT_EDGES_10         = 4'h5;
  localparam logic [3:0]  HAT_EDGES_11         = 4'h9;
  localparam logic [1:0]  HAT_SKIP_EDGES       = 2'h3;

  typedef enum logic [1:0] {
    HAT_SP_IDLE  = 2'b00,
    HAT_SP_COUNT = 2'b01,
    HAT_SP_DONE  = 2'b10
  } hat_sp_state_t;

endpackage : hat_pkg

// ===== rtl/hat_speed_meas.sv
`timescale 1ns/1ps
module hat_speed_meas
  import hat_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [7:0]       options,
  input  wire logic             window_start,
  input  wire logic             window_end,
  input  wire logic             guard_done,
  input  wire logic             edge_seen,
  output logic      [CNT_W-1:0] speed_count,
  output logic                  speed_valid
);

  // ---------------------------------------------------------------
  // option decode
  // ---------------------------------------------------------------
  function automatic logic [3:0] hat_edges(input logic [1:0] sel);
    unique case (sel)
      2'b00: hat_edges = HAT_EDGES_00;
      2'b01: hat_edges = HAT_EDGES_01;
      2'b10: hat_edges = HAT_EDGES_10;
      2'b11: hat_edges = HAT_EDGES_11;
    endcase
  endfunction : hat_edges

  wire logic [3:0] need_edges = hat_edges(options[HAT_OPT_EDG_HI:HAT_OPT_EDG_LO]); // [R15]
  wire logic       mode2      = options[HAT_OPT_MODE]; // [R16]
  wire logic       skip_on    = mode2 & options[HAT_OPT_SKIP]; // [R18]

  hat_sp_state_t    state_q;
  logic [3:0]       edges_q;
  logic [1:0]       skipped_q;
  logic [CNT_W-1:0] ticks_q;

  // mode 2 waits for the guard time before edges count
  wire logic armed     = ~mode2 | guard_done;
  wire logic skip_edge = skip_on & (skipped_q != HAT_SKIP_EDGES); // [R18]
  wire logic count_ok  = edge_seen & armed & ~skip_edge;
  wire logic full      = (edges_q == need_edges);
  wire logic partial   = (edges_q != 4'h0) & ~full;
  wire logic [CNT_W-1:0] part_code = options[HAT_OPT_SLOW] ?
    CNT_W'(HAT_SPEED_PART_SLOW1) : CNT_W'(HAT_SPEED_PART_SLOW0);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= HAT_SP_IDLE;
      edges_q     <= 4'h0;
      skipped_q   <= 2'h0;
      ticks_q     <= '0;
      speed_count <= '1;
      speed_valid <= 1'b0;
    end else if (clk_en) begin
      speed_valid <= 1'b0;
      unique case (state_q)
        HAT_SP_IDLE: begin
          if (window_start) begin
            state_q   <= HAT_SP_COUNT;
            edges_q   <= 4'h0;
            skipped_q <= 2'h0;
            ticks_q   <= '0;
          end
        end
        HAT_SP_COUNT: begin
          if (edges_q != 4'h0 && ticks_q != '1) ticks_q <= ticks_q + 1'b1;
          if (edge_seen && armed && skip_edge) skipped_q <= skipped_q + 2'h1;
          if (count_ok && !full) edges_q <= edges_q + 4'h1;
          if (full || window_end) state_q <= HAT_SP_DONE;
        end
        HAT_SP_DONE: begin
          // partial count forces the coded reading
          speed_count <= partial ? part_code : (full ? ticks_q : '1); // [R14]
          speed_valid <= 1'b1;
          state_q     <= HAT_SP_IDLE;
        end
        default: state_q <= HAT_SP_IDLE;
      endcase
    end
  end

endmodule : hat_speed_meas

// ===== tb/hat_regs_props.sv
`timescale 1ns/1ps
module hat_regs_props
  import hat_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [7:0]  special_func,
  input wire logic [7:0]  volt_enable,
  input wire logic [11:0] reading_standby,
  input wire logic [11:0] reading_battery,
  input wire logic        reading_strobe,
  input wire logic [7:0]  standby_low_limit,
  input wire logic [7:0]  battery_high_limit,
  input wire logic [2:0]  zone_status,
  input wire logic [7:0]  rail_status,
  input wire logic        monitor_alert_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // one quiet cycle before and after keeps this valid for a lagging copy
  wire wr_stat  = reg_wr && reg_addr == HAT_OFF_RAIL_STAT;
  wire keep_sb  = volt_enable[HAT_VEN_VTR] && !(wr_stat && reg_wdata[HAT_STAT_SB]);
  wire keep_bat = volt_enable[HAT_VEN_VBAT] && !(wr_stat && reg_wdata[HAT_STAT_BAT]);

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_sticky_standby: assert property (keep_sb ##1 rail_status[0] && keep_sb ##1 keep_sb
    |-> rail_status[0]) else $error("standby status lost");
  a_sticky_battery: assert property (keep_bat ##1 rail_status[1] && keep_bat ##1 keep_bat
    |-> rail_status[1]) else $error("battery status lost");
  a_low_limit_sets: assert property (reading_strobe && volt_enable[HAT_VEN_VTR]
    && reading_standby[11:4] <= standby_low_limit |-> ##[1:2] rail_status[0])
    else $error("standby low fault not flagged");
  a_high_limit_sets: assert property (reading_strobe && volt_enable[HAT_VEN_VBAT]
    && reading_battery[11:4] > battery_high_limit |-> ##[1:2] rail_status[1])
    else $error("battery high fault not flagged");
  a_rail_upper_zero: assert property (rail_status[7:2] == 6'h00)
    else $error("reserved status bits set");
  a_status_read_zero: assert property (reg_rd && reg_addr == HAT_OFF_RAIL_STAT
    |=> reg_rdata[7:2] == 6'h00) else $error("reserved status bits read back");
  a_alert_needs_gae: assert property (!special_func[2] ##1 !special_func[2]
    |-> monitor_alert_n) else $error("alert without global enable");
  a_alert_needs_event: assert property (zone_status == 3'h0 ##1 zone_status == 3'h0
    |-> monitor_alert_n) else $error("alert without thermal status");
endmodule : hat_regs_props

bind hat_regs hat_regs_props u_props (
  .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .special_func(special_func),
  .volt_enable(volt_enable), .reading_standby(reading_standby),
  .reading_battery(reading_battery), .reading_strobe(reading_strobe),
  .standby_low_limit(standby_low_limit), .battery_high_limit(battery_high_limit),
  .zone_status(zone_status), .rail_status(rail_status), .monitor_alert_n(monitor_alert_n)
);

// ===== tb/hat_fan_model.sv
`timescale 1ns/1ps
module hat_fan_model (
  input  wire logic       mclk,
  output logic      [2:0] speed_pin
);
  // pulled-up tach lines rest high between bursts
  initial speed_pin = 3'b111;

  // returns right at the last rising edge so the result pulse is not missed
  task automatic spin(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      speed_pin = 3'b000;
      repeat (half) @(posedge mclk);
      #1;
      speed_pin = 3'b111;
      if (i < n - 1) begin
        repeat (half) @(posedge mclk);
        #1;
      end
    end
  endtask : spin
endmodule : hat_fan_model

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  import hat_pkg::*;
  logic        mclk, rst_n, reg_wr, reg_rd, config_lock, reading_strobe, monitor_alert_n;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, special_func, volt_enable, rail_status;
  logic [11:0] rd[10];
  logic [9:0]  upper_byte_read;
  logic [2:0]  zone_event, win_start, win_end, guard, speed_pin, valid, zone_status;
  logic [47:0] speed_reading;
  int          mismatches, checked;

  hat_regs dut (
    .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .config_lock(config_lock), .special_func(special_func), .volt_enable(volt_enable),
    .reading_standby(rd[0]), .reading_battery(rd[1]), .reading_rd2(rd[2]),
    .reading_rd1(rd[3]), .reading_12v(rd[4]), .reading_ambient(rd[5]), .reading_5v(rd[6]),
    .reading_2v5(rd[7]), .reading_main(rd[8]), .reading_core(rd[9]),
    .reading_strobe(reading_strobe), .standby_low_limit(8'h40), .standby_high_limit(8'hC0),
    .battery_low_limit(8'h40), .battery_high_limit(8'hC0), .upper_byte_read(upper_byte_read),
    .zone_event(zone_event), .speed_window_start(win_start), .speed_window_end(win_end),
    .speed_guard_done(guard), .speed_pin(speed_pin), .speed_reading(speed_reading),
    .speed_reading_valid(valid), .zone_status(zone_status), .rail_status(rail_status),
    .monitor_alert_n(monitor_alert_n)
  );
  hat_fan_model fan (.mclk(mclk), .speed_pin(speed_pin));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    tick();
    reg_rd = 1'b1;
    reg_addr = a;
    tick();
    reg_rd = 1'b0;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask : rdc

  task automatic strobe();
    reading_strobe = 1'b1;
    tick();
    reading_strobe = 1'b0;
    tick();
  endtask : strobe

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] a[10] = '{8'h82, 8'h83, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h90, 8'h91, 8'h92, 8'h8F};
    logic [7:0] e[10] = '{8'h0E, 8'h00, 8'h4D, 8'h4D, 8'h0E, 8'h0E, 8'h04, 8'h04, 8'h04, 8'h00};
    for (int i = 0; i < 10; i++) rdc(a[i], e[i]);
  endtask : t_reset

  task automatic t_lock();
    wr(8'h82, 8'hFF);
    rdc(8'h82, 8'h0F);
    config_lock = 1'b1;
    wr(8'h82, 8'h00);
    wr(8'h90, 8'h08);
    rdc(8'h82, 8'h0F);
    rdc(8'h90, 8'h04);
    config_lock = 1'b0;
    // only the read-only twin is poked, the writable test pair stays untouched
    wr(8'h8A, 8'h00);
    rdc(8'h8A, 8'h4D);
    for (int i = 0; i < 3; i++) begin
      wr(8'h90 + 8'(i), 8'hFF);
      rdc(8'h90 + 8'(i), 8'h1F);
    end
  endtask : t_lock

  task automatic t_rail();
    special_func = 8'h04;
    volt_enable = 8'h12;
    rd[0] = 12'h400;
    rd[1] = 12'hC00;
    strobe();
    rdc(8'h83, 8'h01);
    rd[0] = 12'h800;
    strobe();
    special_func = 8'h00;
    wr(8'h82, 8'h0E);
    rdc(8'h83, 8'h01);
    wr(8'h83, 8'h00);
    rdc(8'h83, 8'h01);
    wr(8'h83, 8'hFF);
    rdc(8'h83, 8'h00);
    rd[1] = 12'hC10;
    strobe();
    rdc(8'h83, 8'h02);
    rd[1] = 12'h800;
    volt_enable = 8'h10;
    tick(2);
    rdc(8'h83, 8'h00);
    volt_enable = 8'h12;
  endtask : t_rail

  task automatic t_lsb();
    for (int i = 0; i < 10; i++) rd[i] = {8'h80, 4'(i + 1)};
    upper_byte_read = 10'h3FF;
    tick();
    upper_byte_read = 10'h000;
    for (int k = 0; k < 5; k++) rdc(8'h84 + 8'(k), {4'(2 * k + 1), 4'(2 * k + 2)});
    rd[0] = 12'h80F;
    tick();
    rdc(8'h84, 8'h12);
  endtask : t_lsb

  task automatic t_alert();
    special_func = 8'h04;
    zone_event = 3'b001;
    tick(6);
    chk(16'(zone_status), 16'h0001);
    chk(16'(monitor_alert_n), 16'h0001);
    wr(8'h82, 8'h0F);
    tick(4);
    chk(16'(monitor_alert_n), 16'h0000);
    special_func = 8'h00;
    tick(2);
    chk(16'(monitor_alert_n), 16'h0001);
    special_func = 8'h04;
    zone_event = 3'b000;
    tick(6);
    chk(16'(monitor_alert_n), 16'h0000);
    wr(8'h82, 8'h0D);
    tick(3);
    chk(16'(zone_status), 16'h0000);
    chk(16'(monitor_alert_n), 16'h0001);
  endtask : t_alert

  task automatic t_speed();
    logic [7:0]  opt[9] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h06, 8'h07, 8'h18, 8'h18, 8'h08};
    int          n[9] = '{2, 3, 5, 9, 8, 8, 4, 5, 2};
    // ticks run from the first edge through the cycle that sees the count full
    logic [15:0] e[9] = '{16'h0009, 16'h0011, 16'h0021, 16'h0041, 16'hFFFF, 16'hFFFE, 16'hFFFF,
                          16'h0009, 16'h0009};
    for (int t = 0; t < 9; t++) begin
      for (int i = 0; i < 3; i++) wr(8'h90 + 8'(i), opt[t]);
      guard = (t >= 6) ? 3'b111 : 3'b000;
      win_start = 3'b111;
      tick();
      win_start = 3'b000;
      fan.spin(n[t], 4);
      for (int i = 0; i < 40 && valid !== 3'b111; i++) begin
        win_end = (i == 20) ? 3'b111 : 3'b000;
        tick();
      end
      win_end = 3'b000;
      if (valid !== 3'b111) begin
        mismatches++;
        stop_test();
      end
      for (int j = 0; j < 3; j++) chk(speed_reading[16 * j +: 16], e[t]);
    end
    // unused inputs go back to the standard mode
    for (int i = 0; i < 3; i++) wr(8'h90 + 8'(i), HAT_RST_SPEED);
  endtask : t_speed

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, config_lock, reading_strobe} = '0;
    {reg_addr, reg_wdata, special_func, volt_enable} = '0;
    {upper_byte_read, zone_event, win_start, win_end, guard} = '0;
    for (int i = 0; i < 10; i++) rd[i] = 12'h800;
    mismatches = 0;
    checked = 0;
    repeat (3) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_lock();
    t_rail();
    t_lsb();
    t_alert();
    t_speed();
    stop_test();
  end
endmodule : tb
